// *** rtl/asc_pkg.sv ***
// Purpose: Shared constants for the analog selector and scaling amplifier.
// Assumes: 40 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Analog words are 16-bit two's complement, except the 10-bit unsigned physical input code.
package asc_pkg;

  localparam int          DATA_W       = 16;
  localparam int          AXI_AW       = 6;
  localparam int          BLK_W        = 4;
  localparam int          PHYS_W       = 10;

  // Register byte offsets
  localparam logic [5:0]  ADDR_CTRL    = 6'h00;
  localparam logic [5:0]  ADDR_PRESET_A = 6'h04;
  localparam logic [5:0]  ADDR_PRESET_B = 6'h08;
  localparam logic [5:0]  ADDR_PRESET_C = 6'h0c;
  localparam logic [5:0]  ADDR_PRESET_D = 6'h10;
  localparam logic [5:0]  ADDR_LINK_CFG = 6'h14;
  localparam logic [5:0]  ADDR_GAIN    = 6'h18;
  localparam logic [5:0]  ADDR_OFFSET  = 6'h1c;
  localparam logic [5:0]  ADDR_AMP_SRC = 6'h20;
  localparam logic [5:0]  ADDR_MUX_RES = 6'h24;
  localparam logic [5:0]  ADDR_AMP_RES = 6'h28;
  localparam logic [5:0]  ADDR_FLAGS   = 6'h2c;

  // Control and link configuration field positions
  localparam int          CTRL_LEGACY_BIT  = 0;
  localparam int          CTRL_AMP_SRC_BIT = 1;
  localparam int          CTRL_MUX_DP_LSB  = 4;
  localparam int          CTRL_AMP_DP_LSB  = 6;
  localparam int          LINK_EN_BIT      = 7;
  localparam int          LINK_FIELD_W     = 8;

  // Values after reset
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] PRESET_RST   = 16'h0000;
  localparam logic [31:0] LINK_RST     = 32'h0000_0000;
  localparam logic [15:0] GAIN_RST     = 16'h0064;
  localparam logic [15:0] OFFSET_RST   = 16'h0000;

  // Arithmetic limits
  localparam logic signed [15:0] GAIN_MAX   = 16'sh03e8;
  localparam logic signed [15:0] GAIN_MIN   = 16'shfc18;
  localparam logic signed [15:0] OFFSET_MAX = 16'sh2710;
  localparam logic signed [15:0] OFFSET_MIN = 16'shd8f0;
  localparam logic signed [31:0] GAIN_SCALE = 32'sh0000_0064;
  localparam logic signed [32:0] SUM_MAX    = 33'sh0_0000_7fff;
  localparam logic signed [32:0] SUM_MIN    = 33'sh1_ffff_8000;
  localparam logic [15:0]        RES_MAX    = 16'h7fff;
  localparam logic [15:0]        RES_MIN    = 16'h8000;
  localparam logic [9:0]         PHYS_MAX   = 10'h3e8;

  // Evaluation cycle timing
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          SCAN_PERIOD_NS = 1000;
  localparam int          SCAN_CYC       = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DIV_W          = 6;
  localparam logic [5:0]  SCAN_LAST      = 6'(SCAN_CYC - 1);

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// *** rtl/asc_amp_if.sv ***
// Purpose: Carries operands and result between the register front end and the amplifier.
// Assumes: All signals on the system clock.
// Notes:   Tick marks one evaluation cycle.
`timescale 1ns/1ps
interface asc_amp_if;
  logic               tick;
  logic               legacy_gain;
  logic signed [15:0] value_in;
  logic signed [15:0] gain;
  logic signed [15:0] offset;
  logic signed [15:0] result;
  logic               saturated;

  modport ctrl (output tick, legacy_gain, value_in, gain, offset,
                input  result, saturated);
  modport amp  (input  tick, legacy_gain, value_in, gain, offset,
                output result, saturated);
endinterface

// *** rtl/asc_amp.sv ***
// Purpose: Scaling amplifier, input times gain in hundredths plus offset.
// Assumes: Operands stable for the tick cycle.
// Notes:   Result saturates at the signed 16-bit limits.
`timescale 1ns/1ps
module asc_amp (
  input  wire logic    i_sys_clk,
  input  wire logic    i_rst,
  asc_amp_if.amp       bus
);

  typedef struct packed {
    logic [15:0] result;
    logic        saturated;
  } asc_amp_st_t;

  asc_amp_st_t        st_reg;
  asc_amp_st_t        st_next;
  logic signed [15:0] eff_gain;
  logic signed [15:0] eff_off;
  logic signed [31:0] prod;
  logic signed [31:0] scaled;
  logic signed [32:0] sum;
  logic [15:0]        sum_lo;
  logic               ovf;
  logic               unf;

  always_comb begin
    eff_gain = bus.gain;
    if (bus.legacy_gain && bus.gain < 16'sh0000) begin
      eff_gain = 16'sh0000;
    end else if (bus.gain > asc_pkg::GAIN_MAX) begin
      eff_gain = asc_pkg::GAIN_MAX;
    end else if (bus.gain < asc_pkg::GAIN_MIN) begin
      eff_gain = asc_pkg::GAIN_MIN;
    end
    eff_off = bus.offset;
    if (bus.offset > asc_pkg::OFFSET_MAX) begin
      eff_off = asc_pkg::OFFSET_MAX;
    end else if (bus.offset < asc_pkg::OFFSET_MIN) begin
      eff_off = asc_pkg::OFFSET_MIN;
    end
    // Gain is a count of hundredths; truncation is toward zero
    prod   = $signed({{16{bus.value_in[15]}}, bus.value_in}) *
             $signed({{16{eff_gain[15]}}, eff_gain});
    scaled = prod / asc_pkg::GAIN_SCALE;
    sum    = $signed({scaled[31], scaled}) + $signed({{17{eff_off[15]}}, eff_off});
    sum_lo = sum[15:0];
    ovf    = sum > asc_pkg::SUM_MAX;
    unf    = sum < asc_pkg::SUM_MIN;
  end

  always_comb begin
    st_next           = st_reg;
    st_next.saturated = 1'b0;
    if (bus.tick) begin
      if (ovf) begin
        st_next.result = asc_pkg::RES_MAX;
      end else if (unf) begin
        st_next.result = asc_pkg::RES_MIN;
      end else begin
        st_next.result = sum_lo;
      end
      st_next.saturated = ovf | unf;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.result    = st_reg.result;
  assign bus.saturated = st_reg.saturated;

  property p_amp_calc;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.tick && !ovf && !unf |=> bus.result == $past(sum_lo) && !bus.saturated;
  endproperty
  a_amp_calc: assert property (p_amp_calc) else $error("amp result not gain*in+offset");

  property p_amp_sat_hi;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.tick && ovf |=> bus.result == 16'sh7fff && bus.saturated;
  endproperty
  a_amp_sat_hi: assert property (p_amp_sat_hi) else $error("amp overflow not clipped");

  property p_amp_sat_lo;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.tick && unf |=> bus.result == 16'sh8000 && bus.saturated;
  endproperty
  a_amp_sat_lo: assert property (p_amp_sat_lo) else $error("amp underflow not clipped");

  property p_amp_gain_range;
    @(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |-> eff_gain <= 16'sh03e8 && eff_gain >= 16'shfc18;
  endproperty
  a_amp_gain_range: assert property (p_amp_gain_range) else $error("gain out of range");

  property p_amp_legacy;
    @(posedge i_sys_clk) disable iff (i_rst)
      bus.legacy_gain |-> eff_gain >= 16'sh0000;
  endproperty
  a_amp_legacy: assert property (p_amp_legacy) else $error("legacy gain negative");

  property p_amp_offset;
    @(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |-> eff_off <= 16'sh2710 && eff_off >= 16'shd8f0;
  endproperty
  a_amp_offset: assert property (p_amp_offset) else $error("offset out of range");

endmodule

// *** rtl/asc_top.sv ***
// Purpose: Four-way analog selector with a scaling amplifier behind AXI4-Lite registers.
// Assumes: Selector and link inputs come from logic on i_sys_clk; the physical
//          analog code arrives from outside and is synchronised.
// Notes:   Results move once per evaluation tick from the internal divider.
// Operation
// - Enabled selector outputs the chosen preset value
// - Disabled selector outputs zero regardless of selects
// - Selects 00,01,10,11 choose presets A,B,C,D
// - Presets and result are signed 16-bit values
// - Each preset is fixed or linked block value
// - Selector decimal setting only affects display
// - Amplifier outputs input times gain plus offset
// - Gain accepted from -10.00 to 10.00
// - Offset accepted from -10000 to 10000
// - Legacy generation limits gain to 0..10.00
// - Amplifier result is signed 16-bit value
// - Physical input 0..10 V reads 0..1000
// - Amplifier decimal setting only affects display
`timescale 1ns/1ps
module asc_top #(
  parameter int NUM_BLOCKS = 16
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_axi_awvalid,
  input  wire logic [5:0]                i_axi_awaddr,
  output logic                           o_axi_awready,
  input  wire logic                      i_axi_wvalid,
  input  wire logic [31:0]               i_axi_wdata,
  input  wire logic [3:0]                i_axi_wstrb,
  output logic                           o_axi_wready,
  output logic                           o_axi_bvalid,
  output logic [1:0]                     o_axi_bresp,
  input  wire logic                      i_axi_bready,
  input  wire logic                      i_axi_arvalid,
  input  wire logic [5:0]                i_axi_araddr,
  output logic                           o_axi_arready,
  output logic                           o_axi_rvalid,
  output logic [31:0]                    o_axi_rdata,
  output logic [1:0]                     o_axi_rresp,
  input  wire logic                      i_axi_rready,
  input  wire logic                      i_enable,
  input  wire logic                      i_select_upper,
  input  wire logic                      i_select_lower,
  input  wire logic [NUM_BLOCKS*16-1:0]  i_link_values,
  input  wire logic [9:0]                i_physical_analog_input,
  output logic [15:0]                    o_analog_result,
  output logic [15:0]                    o_amp_result,
  output logic [1:0]                     o_mux_decimals,
  output logic [1:0]                     o_amp_decimals
);

  typedef struct packed {
    logic             aw_got;
    logic [5:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             b_valid;
    logic [1:0]       b_resp;
    logic             r_valid;
    logic [31:0]      r_data;
    logic [1:0]       r_resp;
    logic [7:0]       ctrl;
    logic [3:0][15:0] preset;
    logic [31:0]      link_cfg;
    logic [15:0]      gain;
    logic [15:0]      offset;
    logic [3:0]       amp_src;
    logic [15:0]      mux_result;
    logic             sat_flag;
    logic [5:0]       div_cnt;
    logic             tick;
    logic [1:0][9:0]  phys_sync;
  } asc_state_t;

  localparam asc_state_t ST_RST = '{
    ctrl:     asc_pkg::CTRL_RST,
    preset:   {4{asc_pkg::PRESET_RST}},
    link_cfg: asc_pkg::LINK_RST,
    gain:     asc_pkg::GAIN_RST,
    offset:   asc_pkg::OFFSET_RST,
    default:  '0
  };

  localparam int SCAN_N = asc_pkg::SCAN_CYC;
  // Edges from the idle cycle after a tick to the next tick
  localparam int TICK_GAP = SCAN_N - 1;

  asc_state_t    st_reg;
  asc_state_t    st_next;
  logic [15:0]   preset_eff [4];
  logic [1:0]    sel;
  logic [15:0]   sel_value;
  logic [9:0]    phys_clamped;
  logic [15:0]   amp_in;
  logic          wr_fire;
  logic          flag_clr;

  asc_amp_if amp_bus ();

  function automatic logic [15:0] link_pick(input logic [NUM_BLOCKS*16-1:0] v,
                                            input logic [3:0]               idx);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < NUM_BLOCKS; k++) begin
      if (idx == 4'(k)) begin
        r = v[k*16 +: 16];
      end
    end
    return r;
  endfunction

  function automatic logic addr_mapped(input logic [5:0] a);
    return (a[1:0] == 2'h0) && (a <= asc_pkg::ADDR_FLAGS);
  endfunction

  function automatic logic [31:0] read_word(input logic [5:0] a, input asc_state_t s,
                                            input logic [15:0] amp_res);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      asc_pkg::ADDR_CTRL:     r = {24'h00_0000, s.ctrl};
      asc_pkg::ADDR_PRESET_A: r = {16'h0000, s.preset[0]};
      asc_pkg::ADDR_PRESET_B: r = {16'h0000, s.preset[1]};
      asc_pkg::ADDR_PRESET_C: r = {16'h0000, s.preset[2]};
      asc_pkg::ADDR_PRESET_D: r = {16'h0000, s.preset[3]};
      asc_pkg::ADDR_LINK_CFG: r = s.link_cfg;
      asc_pkg::ADDR_GAIN:     r = {16'h0000, s.gain};
      asc_pkg::ADDR_OFFSET:   r = {16'h0000, s.offset};
      asc_pkg::ADDR_AMP_SRC:  r = {28'h000_0000, s.amp_src};
      asc_pkg::ADDR_MUX_RES:  r = {16'h0000, s.mux_result};
      asc_pkg::ADDR_AMP_RES:  r = {16'h0000, amp_res};
      asc_pkg::ADDR_FLAGS:    r = {31'h0000_0000, s.sat_flag};
      default:                r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Each preset is either its stored word or a live value of another block
  for (genvar g = 0; g < 4; g++) begin : g_preset
    assign preset_eff[g] = st_reg.link_cfg[g*asc_pkg::LINK_FIELD_W + asc_pkg::LINK_EN_BIT]
                         ? link_pick(i_link_values,
                                     st_reg.link_cfg[g*asc_pkg::LINK_FIELD_W +: 4])
                         : st_reg.preset[g];
  end

  assign sel       = {i_select_upper, i_select_lower};
  assign sel_value = preset_eff[sel];

  // ADC codes above full scale are clipped rather than wrapped
  assign phys_clamped = (st_reg.phys_sync[1] > asc_pkg::PHYS_MAX)
                      ? asc_pkg::PHYS_MAX : st_reg.phys_sync[1];
  assign amp_in = st_reg.ctrl[asc_pkg::CTRL_AMP_SRC_BIT]
                ? link_pick(i_link_values, st_reg.amp_src)
                : {6'h00, phys_clamped};

  assign amp_bus.tick        = st_reg.tick;
  assign amp_bus.legacy_gain = st_reg.ctrl[asc_pkg::CTRL_LEGACY_BIT];
  assign amp_bus.value_in    = amp_in;
  assign amp_bus.gain        = st_reg.gain;
  assign amp_bus.offset      = st_reg.offset;

  asc_amp u_amp (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (amp_bus.amp)
  );

  assign wr_fire  = st_reg.aw_got && st_reg.w_got && !st_reg.b_valid;
  assign flag_clr = wr_fire && (st_reg.aw_addr == asc_pkg::ADDR_FLAGS) &&
                    st_reg.w_strb[0] && st_reg.w_data[0];

  always_comb begin
    logic [31:0] merged;
    merged  = strb_merge(read_word(st_reg.aw_addr, st_reg, amp_bus.result),
                         st_reg.w_data, st_reg.w_strb);
    st_next = st_reg;

    // Evaluation tick divider
    st_next.tick = 1'b0;
    if (st_reg.div_cnt == asc_pkg::SCAN_LAST) begin
      st_next.div_cnt = '0;
      st_next.tick    = 1'b1;
    end else begin
      st_next.div_cnt = 6'(st_reg.div_cnt + 6'h01);
    end

    st_next.phys_sync[0] = i_physical_analog_input;
    st_next.phys_sync[1] = st_reg.phys_sync[0];

    // Write address and data are taken independently, in either order
    if (o_axi_awready && i_axi_awvalid) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = i_axi_awaddr;
    end
    if (o_axi_wready && i_axi_wvalid) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = i_axi_wdata;
      st_next.w_strb = i_axi_wstrb;
    end
    if (wr_fire) begin
      st_next.aw_got  = 1'b0;
      st_next.w_got   = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp  = addr_mapped(st_reg.aw_addr) ? asc_pkg::RESP_OKAY
                                                    : asc_pkg::RESP_SLVERR;
      unique case (st_reg.aw_addr)
        asc_pkg::ADDR_CTRL:     st_next.ctrl      = merged[7:0];
        asc_pkg::ADDR_PRESET_A: st_next.preset[0] = merged[15:0];
        asc_pkg::ADDR_PRESET_B: st_next.preset[1] = merged[15:0];
        asc_pkg::ADDR_PRESET_C: st_next.preset[2] = merged[15:0];
        asc_pkg::ADDR_PRESET_D: st_next.preset[3] = merged[15:0];
        asc_pkg::ADDR_LINK_CFG: st_next.link_cfg  = merged;
        asc_pkg::ADDR_GAIN:     st_next.gain      = merged[15:0];
        asc_pkg::ADDR_OFFSET:   st_next.offset    = merged[15:0];
        asc_pkg::ADDR_AMP_SRC:  st_next.amp_src   = merged[3:0];
        default:                st_next.ctrl      = st_reg.ctrl;
      endcase
    end
    if (st_reg.b_valid && i_axi_bready) begin
      st_next.b_valid = 1'b0;
    end

    // Saturation is sticky; a new event beats a clear in the same cycle
    st_next.sat_flag = (st_reg.sat_flag & ~flag_clr) | amp_bus.saturated;

    if (o_axi_arready && i_axi_arvalid) begin
      st_next.r_valid = 1'b1;
      st_next.r_data  = read_word(i_axi_araddr, st_reg, amp_bus.result);
      st_next.r_resp  = addr_mapped(i_axi_araddr) ? asc_pkg::RESP_OKAY
                                                  : asc_pkg::RESP_SLVERR;
    end else if (st_reg.r_valid && i_axi_rready) begin
      st_next.r_valid = 1'b0;
    end

    // Selector result, sampled once per evaluation cycle
    if (st_reg.tick) begin
      if (i_enable) begin
        st_next.mux_result = sel_value;
      end else begin
        st_next.mux_result = 16'h0000;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_axi_awready   = !st_reg.aw_got && !st_reg.b_valid;
  assign o_axi_wready    = !st_reg.w_got && !st_reg.b_valid;
  assign o_axi_bvalid    = st_reg.b_valid;
  assign o_axi_bresp     = st_reg.b_resp;
  assign o_axi_arready   = !st_reg.r_valid;
  assign o_axi_rvalid    = st_reg.r_valid;
  assign o_axi_rdata     = st_reg.r_data;
  assign o_axi_rresp     = st_reg.r_resp;
  assign o_analog_result = st_reg.mux_result;
  assign o_amp_result    = amp_bus.result;
  // Decimal settings only go out for display, never into arithmetic
  assign o_mux_decimals  = st_reg.ctrl[asc_pkg::CTRL_MUX_DP_LSB +: 2];
  assign o_amp_decimals  = st_reg.ctrl[asc_pkg::CTRL_AMP_DP_LSB +: 2];

  sequence s_enabled_tick;
    st_reg.tick && i_enable;
  endsequence

  property p_mux_zero;
    @(posedge i_sys_clk) disable iff (i_rst)
      st_reg.tick && !i_enable |=> o_analog_result == 16'h0000;
  endproperty
  a_mux_zero: assert property (p_mux_zero) else $error("disabled selector not zero");

  property p_mux_pick;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_enabled_tick |=> o_analog_result == $past(sel_value);
  endproperty
  a_mux_pick: assert property (p_mux_pick) else $error("selector result wrong");

  property p_mux_decode;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_enabled_tick ##0 (!i_select_upper && i_select_lower && !st_reg.link_cfg[15])
      |=> o_analog_result == $past(st_reg.preset[1]);
  endproperty
  a_mux_decode: assert property (p_mux_decode) else $error("select 01 not preset b");

  property p_mux_link;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_enabled_tick ##0 (sel == 2'h3 && st_reg.link_cfg[31])
      |=> o_analog_result == $past(preset_eff[3]);
  endproperty
  a_mux_link: assert property (p_mux_link) else $error("linked preset not used");

  property p_mux_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !st_reg.tick |=> $stable(o_analog_result);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("result moved between ticks");

  property p_tick_period;
    @(posedge i_sys_clk) disable iff (i_rst)
      st_reg.tick |=> !st_reg.tick [*1] ##[TICK_GAP:TICK_GAP] st_reg.tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_sat_wins;
    @(posedge i_sys_clk) disable iff (i_rst)
      amp_bus.saturated |=> st_reg.sat_flag;
  endproperty
  a_sat_wins: assert property (p_sat_wins) else $error("saturation event lost");

  property p_flag_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
      flag_clr && !amp_bus.saturated |=> !st_reg.sat_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("saturation flag not cleared");

  property p_phys_range;
    @(posedge i_sys_clk) disable iff (i_rst)
      !st_reg.ctrl[asc_pkg::CTRL_AMP_SRC_BIT] |-> amp_in <= 16'h03e8;
  endproperty
  a_phys_range: assert property (p_phys_range) else $error("physical input above 1000");

endmodule

// *** verification/asc_link_model.sv ***
// Purpose: Stand-in for the neighbouring function blocks that feed link values.
// Assumes: Neighbour values are static during a run.
// Notes:   Block k shows {k,12'h123}, so every link source is distinguishable.
`timescale 1ns/1ps
module asc_link_model #(
  parameter int NUM_BLOCKS = 16
) (
  output logic [NUM_BLOCKS*16-1:0] o_link_values
);
  always_comb begin
    for (int k = 0; k < NUM_BLOCKS; k++) begin
      o_link_values[k*16+:16] = {4'(k), 12'h123};
    end
  end
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the analog selector and amplifier.
// Assumes: One evaluation tick every 40 cycles, so 81 cycles always cover a full tick.
// Notes:   Registers are reached over AXI4-Lite only.
`timescale 1ns/1ps
module tb;
  logic         i_sys_clk = 1'b0;
  logic         i_rst     = 1'b1;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [5:0]   awaddr = 6'h00, araddr = 6'h00;
  logic [31:0]  wdata = 32'h0;
  logic         enable = 1'b0, sel_up = 1'b0, sel_lo = 1'b0;
  logic [9:0]   phys = 10'h000;
  logic [255:0] links;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, mux_dp, amp_dp, resp;
  logic [31:0]  rdata, d;
  logic [15:0]  mux_res, amp_res;
  int           fails = 0, checked = 0, cyc = 0;

  asc_link_model #(.NUM_BLOCKS(16)) link_u (.o_link_values(links));
  asc_top #(.NUM_BLOCKS(16)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_axi_awvalid(awvalid), .i_axi_awaddr(awaddr),
    .o_axi_awready(awready), .i_axi_wvalid(wvalid), .i_axi_wdata(wdata),
    .i_axi_wstrb(4'hf), .o_axi_wready(wready), .o_axi_bvalid(bvalid), .o_axi_bresp(bresp),
    .i_axi_bready(bready), .i_axi_arvalid(arvalid), .i_axi_araddr(araddr),
    .o_axi_arready(arready), .o_axi_rvalid(rvalid), .o_axi_rdata(rdata),
    .o_axi_rresp(rresp), .i_axi_rready(rready), .i_enable(enable),
    .i_select_upper(sel_up), .i_select_lower(sel_lo), .i_link_values(links),
    .i_physical_analog_input(phys), .o_analog_result(mux_res), .o_amp_result(amp_res),
    .o_mux_decimals(mux_dp), .o_amp_decimals(amp_dp));

  always #12.5 i_sys_clk = ~i_sys_clk;

  task automatic wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entry edge first, so bready is never driven twice in one time step
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= v;
    bready  <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge i_sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d    = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (81) @(posedge i_sys_clk);
  endtask

  task automatic t_regs();
    rd(asc_pkg::ADDR_GAIN);
    chk("gain reset", d, 32'h0000_0064);
    rd(asc_pkg::ADDR_CTRL);
    chk("ctrl reset", d, 32'h0);
    rd(6'h30);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, asc_pkg::RESP_SLVERR});
    wr(6'h30, 32'h1234_5678);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, asc_pkg::RESP_SLVERR});
  endtask

  task automatic t_mux();
    logic [15:0] pv [4] = '{16'h8000, 16'h7fff, 16'h0001, 16'hfffe};
    for (int s = 0; s < 4; s++) wr(asc_pkg::ADDR_PRESET_A + 6'(4 * s), {16'h0, pv[s]});
    enable <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      sel_up <= s[1];
      sel_lo <= s[0];
      settle();
      chk("mux result", {16'h0, mux_res}, {16'h0, pv[s]});
    end
    rd(asc_pkg::ADDR_MUX_RES);
    chk("mux readback", {16'h0, d[15:0]}, 32'h0000_fffe);
    enable <= 1'b0;
    settle();
    chk("mux disabled", {16'h0, mux_res}, 32'h0);
    wr(asc_pkg::ADDR_CTRL, 32'h0000_00f0);
    enable <= 1'b1;
    settle();
    chk("decimals", {28'h0, mux_dp, amp_dp}, 32'h0000_000f);
    chk("mux with decimals", {16'h0, mux_res}, 32'h0000_fffe);
    // Presets A and D switched to the live values of blocks 3 and 5
    wr(asc_pkg::ADDR_LINK_CFG, 32'h8500_0083);
    sel_up <= 1'b0;
    sel_lo <= 1'b0;
    settle();
    chk("mux linked", {16'h0, mux_res}, 32'h0000_3123);
    sel_up <= 1'b1;
    sel_lo <= 1'b1;
    settle();
    chk("mux linked d", {16'h0, mux_res}, 32'h0000_5123);
  endtask

  task automatic t_amp();
    logic [7:0]  ct [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02};
    logic [9:0]  ph [7] = '{10'h1f4, 10'h3ff, 10'h3e8, 10'h190, 10'h190, 10'h000, 10'h000};
    logic [15:0] g  [7] = '{16'h00fa, 16'h0064, 16'h07d0, 16'hff06, 16'hff06, 16'h00c8,
                            16'hff38};
    logic [15:0] o  [7] = '{16'hff9c, 16'h0000, 16'h4e20, 16'h0000, 16'h0007, 16'h0000,
                            16'h0000};
    logic [15:0] ex [7] = '{16'h047e, 16'h03e8, 16'h4e20, 16'hfc18, 16'h0007, 16'h7fff,
                            16'h8000};
    wr(asc_pkg::ADDR_AMP_SRC, 32'h0000_0007);
    for (int i = 0; i < 7; i++) begin
      wr(asc_pkg::ADDR_CTRL, {24'h0, ct[i]});
      wr(asc_pkg::ADDR_GAIN, {16'h0, g[i]});
      wr(asc_pkg::ADDR_OFFSET, {16'h0, o[i]});
      phys <= ph[i];
      settle();
      chk("amp result", {16'h0, amp_res}, {16'h0, ex[i]});
    end
    rd(asc_pkg::ADDR_AMP_RES);
    chk("amp readback", {16'h0, d[15:0]}, 32'h0000_8000);
    rd(asc_pkg::ADDR_FLAGS);
    chk("saturation flag", {31'h0, d[0]}, 32'h1);
    wr(asc_pkg::ADDR_GAIN, 32'h0);
    settle();
    chk("amp zero gain", {16'h0, amp_res}, 32'h0);
    wr(asc_pkg::ADDR_FLAGS, 32'h1);
    rd(asc_pkg::ADDR_FLAGS);
    chk("saturation cleared", {31'h0, d[0]}, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_regs();
    t_mux();
    t_amp();
    wrap_up();
  end
endmodule
